/* File: rtl/mcsg_pkg.sv */
// Package for the module clock stop gating block: register map, bit positions, resets.
// Assumes a 32-bit register path with one aligned word per register.
package mcsg_pkg;
    localparam int MCSG_DW = 32;
    localparam int MCSG_AW = 8;
    // Register byte offsets
    localparam logic [7:0] MCSG_OFF_STOP1 = 8'h04;
    localparam logic [7:0] MCSG_OFF_STOP2 = 8'h08;
    // Field positions, first stop register
    localparam int MCSG_BIT_RTC = 13;
    localparam int MCSG_BIT_I2C0 = 9;
    localparam int MCSG_BIT_I2C1 = 8;
    // Field positions, second stop register
    localparam int MCSG_BIT_ADC = 27;
    localparam int MCSG_BIT_DAC = 26;
    localparam int MCSG_BIT_IR0 = 25;
    localparam int MCSG_BIT_IR1 = 24;
    localparam int MCSG_BIT_PU0 = 21;
    localparam int MCSG_BIT_PU1 = 20;
    localparam int MCSG_BIT_SC = 16;
    // Writable masks and reset values
    localparam logic [31:0] MCSG_MASK1 = 32'h0000_2300;
    localparam logic [31:0] MCSG_MASK2 = 32'h0F31_0000;
    localparam logic [31:0] MCSG_RST1 = 32'h0000_0000;
    localparam logic [31:0] MCSG_RST2 = 32'hFFFF_FFFF;
    localparam logic [31:0] MCSG_FILL1 = 32'h0000_0000;
    localparam logic [31:0] MCSG_FILL2 = 32'hFFFF_FFFF;
    // Full-word access strobe
    localparam logic [3:0] MCSG_FULL_STRB = 4'hF;
    localparam int MCSG_NCLK = 10;
    // Clock outputs in order: rtc, i2c0, i2c1, adc, dac, ir0, ir1, pu0, pu1, sc
    localparam int MCSG_IDX_RTC = 0;
    localparam int MCSG_IDX_I2C0 = 1;
    localparam int MCSG_IDX_I2C1 = 2;
    localparam int MCSG_IDX_ADC = 3;
    localparam int MCSG_IDX_DAC = 4;
    localparam int MCSG_IDX_IR0 = 5;
    localparam int MCSG_IDX_IR1 = 6;
    localparam int MCSG_IDX_PU0 = 7;
    localparam int MCSG_IDX_PU1 = 8;
    localparam int MCSG_IDX_SC = 9;
endpackage

/* File: rtl/mcsg_if.sv */
// Interface joining the software-side controller to the stop-register device.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
interface mcsg_if;
    logic req;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
    logic ack;
    logic err;
    logic [31:0] rdata;
    modport device (input req, wr, addr, wdata, strb, output ack, err, rdata);
    modport ctrl (output req, wr, addr, wdata, strb, input ack, err, rdata);
endinterface

/* File: rtl/mcsg_stop_regs.sv */
// Device end: two module stop registers and the glitch-free clock gates they steer.
// Assumes requests on the interface are synchronous to ref_clk and held until ack.
// Assumes the clock tree balances the gated clocks against ref_clk, and that
// software stops a module only once it is idle; nothing here checks that.
// Each gate is a low-phase latch plus an AND, the usual clock-gating shape.
`timescale 1ns/10ps
module mcsg_stop_regs
    import mcsg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Register access
    mcsg_if.device bus,
    // Stop bits and gated clocks to the peripherals
    output logic [mcsg_pkg::MCSG_NCLK-1:0] stopBits,
    output logic [mcsg_pkg::MCSG_NCLK-1:0] gatedClk
);
    import mcsg_pkg::*;

    logic [31:0] stop1;
    logic [31:0] stop2;
    logic take;
    logic hit1;
    logic hit2;
    logic wrOk1;
    logic wrOk2;
    logic rdOk1;
    logic rdOk2;
    logic refuse;
    logic [MCSG_NCLK-1:0] stopVec;
    logic [MCSG_NCLK-1:0] gateOpen;

    // Match one register's offset; anything but a full word is not a hit
    function automatic logic word_hit(input logic [7:0] offset, input logic [3:0] lanes,
        input logic [7:0] regOffset);
        return (offset == regOffset) && (lanes == MCSG_FULL_STRB);
    endfunction

    // Keep the writable bits of a word and force the spare ones to their fixed level
    function automatic logic [31:0] merge_word(input logic [31:0] data,
        input logic [31:0] mask, input logic [31:0] fill);
        return (data & mask) | (fill & ~mask);
    endfunction

    // Gather the ten stop bits, in output order, from the two register words
    function automatic logic [MCSG_NCLK-1:0] stop_vector(input logic [31:0] word1,
        input logic [31:0] word2);
        logic [MCSG_NCLK-1:0] vec;
        vec = {MCSG_NCLK{1'b0}};
        vec[MCSG_IDX_RTC] = word1[MCSG_BIT_RTC];
        vec[MCSG_IDX_I2C0] = word1[MCSG_BIT_I2C0];
        vec[MCSG_IDX_I2C1] = word1[MCSG_BIT_I2C1];
        vec[MCSG_IDX_ADC] = word2[MCSG_BIT_ADC];
        vec[MCSG_IDX_DAC] = word2[MCSG_BIT_DAC];
        vec[MCSG_IDX_IR0] = word2[MCSG_BIT_IR0];
        vec[MCSG_IDX_IR1] = word2[MCSG_BIT_IR1];
        vec[MCSG_IDX_PU0] = word2[MCSG_BIT_PU0];
        vec[MCSG_IDX_PU1] = word2[MCSG_BIT_PU1];
        vec[MCSG_IDX_SC] = word2[MCSG_BIT_SC];
        return vec;
    endfunction

    // Stop levels as they stand in reset, so the level outputs agree with the
    // gates from the first moment instead of showing every module running
    localparam logic [MCSG_NCLK-1:0] STOP_RST = stop_vector(MCSG_RST1, MCSG_RST2);

    // A request is taken at the edge where req is high and no answer stands;
    // a req still held through the answer cycle is therefore not taken twice
    assign take = bus.req && !bus.ack;
    assign hit1 = word_hit(bus.addr, bus.strb, MCSG_OFF_STOP1);
    assign hit2 = word_hit(bus.addr, bus.strb, MCSG_OFF_STOP2);
    assign wrOk1 = take && bus.wr && hit1;
    assign wrOk2 = take && bus.wr && hit2;
    assign rdOk1 = take && !bus.wr && hit1;
    assign rdOk2 = take && !bus.wr && hit2;
    // Partial lanes and unmapped offsets are answered, but change nothing
    assign refuse = take && !(hit1 || hit2);

    // First register: bits 13, 9 and 8 hold state, every other bit stays zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stop1 <= MCSG_RST1;
        end
        else if (wrOk1)
        begin
            stop1 <= merge_word(bus.wdata, MCSG_MASK1, MCSG_FILL1);
        end
    end

    // Second register: spare bits are forced to one whatever software writes
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stop2 <= MCSG_RST2;
        end
        else if (wrOk2)
        begin
            stop2 <= merge_word(bus.wdata, MCSG_MASK2, MCSG_FILL2);
        end
    end

    // Answer every taken request exactly one cycle later, for one cycle
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.ack <= 1'b0;
        end
        else
        begin
            bus.ack <= take;
        end
    end

    // The refusal flag rides in the same cycle as the answer
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.err <= 1'b0;
        end
        else
        begin
            bus.err <= refuse;
        end
    end

    // Read data stands for the answer cycle only and is zero otherwise, so a
    // refused read or a write never shows stale register contents
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus.rdata <= 32'h0000_0000;
        end
        else if (rdOk1)
        begin
            bus.rdata <= stop1;
        end
        else if (rdOk2)
        begin
            bus.rdata <= stop2;
        end
        else
        begin
            bus.rdata <= 32'h0000_0000;
        end
    end

    // Stop bits in output order feed both the level copy and the gates
    assign stopVec = stop_vector(stop1, stop2);

    // Registered copy of the stop bits for peripherals that want a level
    // It comes from flops, so it lags the gate latches by half a cycle after a write
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stopBits <= STOP_RST;
        end
        else
        begin
            stopBits <= stopVec;
        end
    end

    // Clock gates: enable is captured while the clock is low, so a change
    // never clips a high phase. A stopped module just sees no edges and so
    // keeps its own state; no reset is issued to it on stop or restart.
    // A stop bit written at one edge takes hold from the following low phase,
    // so the module still sees the edge that completes the write cycle.
    // gatedClk is a clock, not data: it is the one output not from a flop.
    genvar g;
    generate
        for (g = 0; g < MCSG_NCLK; g++)
        begin : gen_gate
            always_latch
            begin
                if (!ref_clk)
                begin
                    gateOpen[g] = !stopVec[g];
                end
            end
            assign gatedClk[g] = ref_clk & gateOpen[g];
        end
    endgenerate
endmodule

/* File: rtl/mcsg_ctrl.sv */
// Controller end: APB slave with command registers that drive full-word
// read-modify-write sequences on the stop-register interface.
// Assumes an APB master on ref_clk.
`timescale 1ns/10ps
module mcsg_ctrl
    import mcsg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Device side
    mcsg_if.ctrl dev
);
    import mcsg_pkg::*;

    // Own register offsets
    localparam logic [7:0] CTL_TARGET = 8'h00;
    localparam logic [7:0] CTL_SETMASK = 8'h04;
    localparam logic [7:0] CTL_CLRMASK = 8'h08;
    localparam logic [7:0] CTL_GO = 8'h0C;
    localparam logic [7:0] CTL_STATUS = 8'h10;
    localparam logic [7:0] CTL_RESULT = 8'h14;

    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        RD = 4'b0010,
        WR = 4'b0100,
        FIN = 4'b1000
    } mcsg_state_e;

    mcsg_state_e state;
    logic [7:0] target;
    logic [31:0] setMask;
    logic [31:0] clrMask;
    logic [31:0] result;
    logic busy;
    logic fault;
    logic done;
    logic apbWr;
    logic goHit;

    assign apbWr = psel && penable && pwrite && pready;
    assign goHit = apbWr && (paddr == CTL_GO) && pwdata[0] && !busy;

    // APB: one wait state, read data registered
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite)
            begin
                case (paddr)
                    CTL_TARGET: prdata <= {24'h00_0000, target};
                    CTL_SETMASK: prdata <= setMask;
                    CTL_CLRMASK: prdata <= clrMask;
                    CTL_STATUS: prdata <= {29'h0, fault, done, busy};
                    CTL_RESULT: prdata <= result;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            if (psel && penable && !pready && !(paddr inside {CTL_TARGET, CTL_SETMASK,
                CTL_CLRMASK, CTL_GO, CTL_STATUS, CTL_RESULT}))
            begin
                pslverr <= 1'b1;
            end
        end
    end

    // Command registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            target <= MCSG_OFF_STOP1;
            setMask <= 32'h0000_0000;
            clrMask <= 32'h0000_0000;
        end
        else if (apbWr && !busy)
        begin
            if (paddr == CTL_TARGET) target <= pwdata[7:0];
            if (paddr == CTL_SETMASK) setMask <= pwdata;
            if (paddr == CTL_CLRMASK) clrMask <= pwdata;
        end
    end

    // Sequence: read whole word, change wanted bits, write whole word back
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= IDLE;
            dev.req <= 1'b0;
            dev.wr <= 1'b0;
            dev.addr <= 8'h00;
            dev.wdata <= 32'h0000_0000;
            dev.strb <= 4'h0;
            result <= 32'h0000_0000;
            busy <= 1'b0;
            fault <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    if (goHit)
                    begin
                        state <= RD;
                        dev.req <= 1'b1;
                        dev.wr <= 1'b0;
                        dev.addr <= target;
                        dev.strb <= MCSG_FULL_STRB;
                        busy <= 1'b1;
                        done <= 1'b0;
                        fault <= 1'b0;
                    end
                end
                RD:
                begin
                    if (dev.ack)
                    begin
                        dev.req <= 1'b0;
                        if (dev.err)
                        begin
                            fault <= 1'b1;
                            state <= FIN;
                        end
                        else
                        begin
                            // Spare bits take setMask and clrMask like the others; the device forces them back
                            dev.wdata <= (dev.rdata | setMask) & ~clrMask;
                            state <= WR;
                        end
                    end
                end
                WR:
                begin
                    if (!dev.req)
                    begin
                        dev.req <= 1'b1;
                        dev.wr <= 1'b1;
                    end
                    else if (dev.ack)
                    begin
                        dev.req <= 1'b0;
                        fault <= dev.err;
                        result <= dev.wdata;
                        state <= FIN;
                    end
                end
                FIN:
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    dev.wr <= 1'b0;
                    state <= IDLE;
                end
                default: state <= IDLE;
            endcase
        end
    end
endmodule

/* File: verif/mcsg_properties.sv */
// Checker for the interface between the controller end and the stop-register end.
// Assumes one clock, ref_clk, and the asynchronous active-low reset arst_n.
`timescale 1ns/10ps
module mcsg_properties
    import mcsg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Interface signals
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] strb,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // A request is taken when req is high without ack; good means full word, mapped offset
    logic take;
    logic good;
    assign take = req && !ack;
    assign good = strb == MCSG_FULL_STRB && (addr == MCSG_OFF_STOP1 || addr == MCSG_OFF_STOP2);

    // Handshake timing, refusals and spare-bit read values
    AST_ACK_NEXT: assert property (take |=> ack)
        else $error("ack missing one cycle after request");
    AST_ACK_ONE: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (ack |-> $past(take))
        else $error("ack without a taken request");
    AST_REFUSE: assert property (take && !good |=> err && rdata == 32'h0)
        else $error("bad access not refused");
    AST_ACCEPT: assert property (take && good |=> !err)
        else $error("good access refused");
    AST_ERR_ACK: assert property (err |-> ack)
        else $error("err outside ack");
    AST_RD1_ZERO: assert property (take && good && !wr && addr == MCSG_OFF_STOP1
        |=> (rdata & ~MCSG_MASK1) == 32'h0)
        else $error("first register spare bits not zero");
    AST_RD2_ONE: assert property (take && good && !wr && addr == MCSG_OFF_STOP2
        |=> (rdata | MCSG_MASK2) == 32'hFFFF_FFFF)
        else $error("second register spare bits not one");
endmodule

/* File: verif/tb_module_clock_stop_gating.sv */
// Testbench: both ends joined through the interface, driven over APB.
// Assumes the package, interface and both design ends are compiled first.
`timescale 1ns/10ps
module tb_module_clock_stop_gating;
    import mcsg_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr;
    logic [31:0] prdata, rd, st;
    logic er;
    logic [MCSG_NCLK-1:0] stopBits, gatedClk;
    int n_errors = 0, n_compared = 0;

    // Both ends face each other; the checker watches the wire between them
    mcsg_if u_mcsg_if ();
    mcsg_ctrl u_mcsg_ctrl (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .dev(u_mcsg_if.ctrl));
    mcsg_stop_regs u_mcsg_stop_regs (.ref_clk(ref_clk), .arst_n(arst_n), .bus(u_mcsg_if.device),
        .stopBits(stopBits), .gatedClk(gatedClk));
    mcsg_properties u_mcsg_properties (.ref_clk(ref_clk), .arst_n(arst_n), .req(u_mcsg_if.req),
        .wr(u_mcsg_if.wr), .addr(u_mcsg_if.addr), .wdata(u_mcsg_if.wdata),
        .strb(u_mcsg_if.strb), .ack(u_mcsg_if.ack), .err(u_mcsg_if.err),
        .rdata(u_mcsg_if.rdata));

    // 100 MHz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // One APB transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read-modify-write through the controller; rd ends as the word written back
    task automatic go(input logic [7:0] t, input logic [31:0] s, input logic [31:0] c);
        apb(1'b1, 8'h00, {24'h0, t});
        apb(1'b1, 8'h04, s);
        apb(1'b1, 8'h08, c);
        apb(1'b1, 8'h0C, 32'h1);
        for (int k = 0; k < 20; k++)
        begin
            apb(1'b0, 8'h10, 32'h0);
            st = rd;
            if (rd[1:0] === 2'b10)
                break;
        end
        chk({30'h0, st[1:0]}, 32'h2);
        apb(1'b0, 8'h14, 32'h0);
    endtask

    // Running clocks copy the high phase, stopped ones stay low
    task automatic clk_chk(input logic [MCSG_NCLK-1:0] stp);
        @(posedge ref_clk);
        #2;
        chk({22'h0, gatedClk}, {22'h0, ~stp});
        @(negedge ref_clk);
        #2;
        chk({22'h0, gatedClk}, 32'h0);
    endtask

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
    endtask

    task automatic t_reset();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, {24'h0, MCSG_OFF_STOP1});
        chk({22'h0, stopBits}, 32'h3F8);
        clk_chk(10'h3F8);
        go(MCSG_OFF_STOP1, 32'h0, 32'h0);
        chk(rd, 32'h0);
        go(MCSG_OFF_STOP2, 32'h0, 32'h0);
        chk(rd, 32'hFFFF_FFFF);
        $display("TB: t_reset done");
    endtask

    // Flip every stop bit twice; the other bits must survive each write
    task automatic t_bits();
        int pos [10] = '{13, 9, 8, 27, 26, 25, 24, 21, 20, 16};
        logic [31:0] v [2] = '{32'h0, 32'hFFFF_FFFF};
        logic [MCSG_NCLK-1:0] es = 10'h3F8;
        logic [31:0] b;
        int r;
        for (int n = 0; n < 20; n++)
        begin
            r = (n % 10) < 3 ? 0 : 1;
            b = 32'h1 << pos[n % 10];
            if ((v[r] & b) != 0)
                go(r ? MCSG_OFF_STOP2 : MCSG_OFF_STOP1, 32'h0, b);
            else
                go(r ? MCSG_OFF_STOP2 : MCSG_OFF_STOP1, b, 32'h0);
            v[r] = v[r] ^ b;
            es[n % 10] = ~es[n % 10];
            chk(rd, v[r]);
            chk({22'h0, stopBits}, {22'h0, es});
            clk_chk(es);
        end
        $display("TB: t_bits done");
    endtask

    task automatic t_spare();
        go(MCSG_OFF_STOP1, 32'hFFFF_FFFF, 32'h0);
        go(MCSG_OFF_STOP1, 32'h0, 32'h0);
        chk(rd, 32'h0000_2300);
        go(MCSG_OFF_STOP1, 32'h0, 32'hFFFF_FFFF);
        go(MCSG_OFF_STOP2, 32'h0, 32'hFFFF_FFFF);
        go(MCSG_OFF_STOP2, 32'h0, 32'h0);
        chk(rd, 32'hF0CE_FFFF);
        chk({22'h0, stopBits}, 32'h0);
        $display("TB: t_spare done");
    endtask

    // Unmapped APB offset and unmapped device offset, stop bits untouched
    task automatic t_refuse();
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, er}, 32'h1);
        go(8'h0C, 32'hFFFF_FFFF, 32'h0);
        chk({29'h0, st[2:0]}, 32'h6);
        chk({22'h0, stopBits}, 32'h0);
        $display("TB: t_refuse done");
    endtask

    task automatic wrap_up();
        $display("TB: counts errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence, with a second reset after the registers were changed
    initial
    begin
        do_reset();
        t_reset();
        t_bits();
        t_spare();
        t_refuse();
        do_reset();
        t_reset();
        wrap_up();
    end

    // Watchdog: the tests need well under a third of this span
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule
